// ===== scr_host.sv
// Host controller model on the half-duplex serial line
`timescale 1ns/10ps
`default_nettype none
module scr_host #(
	parameter int BIT_CYC = 64
) (
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic i_dev_drive,
	output logic o_txd,
	output logic o_drive
);
	initial begin
		o_txd = 1'b1;
		o_drive = 1'b0;
	end

	// ---------------------------------------------------------------
	// Character and packet tasks
	// ---------------------------------------------------------------
	task automatic send_char(input logic [7:0] d, input logic bad_par);
		logic [10:0] f;
		f = {1'b1, ~^d ^ bad_par, d, 1'b0};
		@(negedge i_clk);
		o_drive = 1'b1;
		for (int i = 0; i < 11; i++) begin
			o_txd = f[i];
			repeat (BIT_CYC) @(negedge i_clk);
		end
		o_drive = 1'b0;
		o_txd = 1'b1;
	endtask

	task automatic recv_char(output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		d = 8'h00;
		while (!(i_dev_drive === 1'b1 && i_line === 1'b0) && n < 16 * BIT_CYC) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 16 * BIT_CYC) return;
		repeat (BIT_CYC / 2) @(negedge i_clk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT_CYC) @(negedge i_clk);
			if (i < 8) d[i] = i_line;
			else ok = (i == 8) ? (^d ^ i_line) : (ok & i_line);
		end
	endtask

	task automatic write_reg(input logic [6:0] node, input logic [6:0] a, input logic [15:0] v);
		send_char({1'b0, node}, 1'b0);
		send_char({1'b1, a}, 1'b0);
		send_char(v[15:8], 1'b0);
		send_char(v[7:0], 1'b0);
	endtask

	task automatic read_reg(input logic [6:0] node, input logic [6:0] a, output logic [15:0] v, output logic ok);
		logic ok_hi;
		logic ok_lo;
		send_char({1'b0, node}, 1'b0);
		fork
			send_char({1'b0, a}, 1'b0);
			begin
				recv_char(v[15:8], ok_hi);
				recv_char(v[7:0], ok_lo);
			end
		join
		ok = ok_hi & ok_lo;
	endtask
endmodule
`default_nettype wire

// ===== scr_monitor.sv
// Concurrent checks on the serial configuration register port outputs
`timescale 1ns/10ps
`default_nettype none
module scr_monitor
	import scr_pkg::*;
#(
	parameter int unsigned CLK_HZ = scr_pkg::CLK_HZ,
	parameter int unsigned STEP_W = 4
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_enable_n,
	input wire logic i_start_cmd,
	input wire logic [STEP_W-1:0] i_step_switches,
	input wire logic o_tx,
	input wire logic o_transceiver_direction,
	input wire scr_pkg::scr_mode_cfg_t o_mode_cfg,
	input wire logic o_speed_mode,
	input wire logic o_position_mode,
	input wire logic o_torque_mode,
	input wire logic o_pulse_dir_input,
	input wire logic o_pwm_dir_input,
	input wire logic o_six_pwm_drive,
	input wire logic o_motor_run,
	input wire logic [STEP_W-1:0] o_step_resolution,
	input wire logic [15:0] o_bit_rate_divisor
);
	localparam int BIT_CYC = CLK_HZ / (int'(RST_BIT_DIV) * BAUD_MULT);
	localparam int REPLY_MIN = 22 * BIT_CYC - BIT_CYC / 4;
	localparam int REPLY_MAX = 22 * BIT_CYC + BIT_CYC / 4;

	// ---------------------------------------------------------------
	// Age since reset and length of each reply
	// ---------------------------------------------------------------
	logic [2:0] age_q;
	logic [15:0] dir_cnt_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			age_q <= 3'h0;
			dir_cnt_q <= 16'h0000;
		end else begin
			age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
			dir_cnt_q <= o_transceiver_direction ? dir_cnt_q + 16'h0001 : 16'h0000;
		end
	end

	default clocking dc @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	tx_idle_a: assert property (!o_transceiver_direction |-> o_tx)
		else $error("tx line not idle while receiving");
	start_bit_a: assert property ($rose(o_transceiver_direction) |-> (!o_tx) [*8])
		else $error("reply does not open with a start bit");
	reply_len_a: assert property ($fell(o_transceiver_direction) && o_bit_rate_divisor == RST_BIT_DIV |->
		dir_cnt_q >= REPLY_MIN && dir_cnt_q <= REPLY_MAX)
		else $error("reply length differs from 22 bit times");
	op_decode_a: assert property (age_q != 3'h0 |->
		{o_speed_mode, o_position_mode, o_torque_mode} == {$past(o_mode_cfg.op_mode) == SCR_OP_SPEED,
		$past(o_mode_cfg.op_mode) == SCR_OP_POSITION, $past(o_mode_cfg.op_mode) == SCR_OP_TORQUE})
		else $error("operation mode decode wrong");
	src_decode_a: assert property (age_q != 3'h0 |->
		{o_pulse_dir_input, o_pwm_dir_input} == {$past(o_mode_cfg.cmd_source) == SCR_SRC_PULSE_DIR,
		$past(o_mode_cfg.cmd_source) == SCR_SRC_PWM_DIR})
		else $error("command source decode wrong");
	bridge_drive_a: assert property (age_q != 3'h0 |-> o_six_pwm_drive == !$past(o_mode_cfg.bridge_combined))
		else $error("bridge drive style wrong");
	step_src_a: assert property (age_q > 3'h2 && $past(o_mode_cfg.step_resolution_source) |->
		o_step_resolution == $past(i_step_switches, 3))
		else $error("step resolution not taken from switches");
	run_off_a: assert property (age_q > 3'h2 && $past(i_enable_n, 3) |-> !o_motor_run)
		else $error("run while enable pin high");
	free_run_a: assert property (age_q > 3'h2 && $past(o_mode_cfg.standby_disable) && !$past(i_enable_n, 3)
		|-> o_motor_run)
		else $error("no run with standby off and enable low");
	standby_hold_a: assert property (age_q != 3'h0 && !$past(o_motor_run) && !$past(i_start_cmd)
		&& !$past(o_mode_cfg.standby_disable) && $past(o_mode_cfg.cmd_source) == SCR_SRC_PULSE_DIR |-> !o_motor_run)
		else $error("standby left without start command");
endmodule

bind scr_port scr_monitor #(.CLK_HZ(CLK_HZ), .STEP_W(STEP_W)) u_scr_monitor (
	.i_clk, .i_reset_n, .i_enable_n, .i_start_cmd, .i_step_switches, .o_tx, .o_transceiver_direction,
	.o_mode_cfg, .o_speed_mode, .o_position_mode, .o_torque_mode, .o_pulse_dir_input, .o_pwm_dir_input,
	.o_six_pwm_drive, .o_motor_run, .o_step_resolution, .o_bit_rate_divisor
);
`default_nettype wire

// ===== scr_pkg.sv
// Shared constants, register map and types of the serial configuration register port
package scr_pkg;

	// ---------------------------------------------------------------
	// Clock and serial timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int unsigned BAUD_MULT = 32;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned DIV_SHIFT = $clog2(BAUD_MULT * OVERSAMPLE);
	localparam logic [3:0] SAMPLE_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hF;
	localparam logic [3:0] STOP_BIT_IDX = 4'hA;
	localparam int unsigned GAP_BITS = 22;

	// ---------------------------------------------------------------
	// Register map (word index; bit 7 of the address byte is write)
	// ---------------------------------------------------------------
	localparam logic [6:0] REG_PART_NUMBER = 7'h00;
	localparam logic [6:0] REG_MOTOR_R = 7'h01;
	localparam logic [6:0] REG_STEP_RES = 7'h02;
	localparam logic [6:0] REG_MOTOR_V = 7'h06;
	localparam logic [6:0] REG_MOTOR_P = 7'h08;
	localparam logic [6:0] REG_PART_VERSION = 7'h14;
	localparam logic [6:0] REG_MODE = 7'h34;
	localparam logic [6:0] REG_NODE_ADDR = 7'h5C;
	localparam logic [6:0] REG_BIT_DIV = 7'h5D;
	localparam int unsigned USER_WORDS = 21;

	localparam logic [15:0] RST_MOTOR_R = 16'h010E;
	localparam logic [15:0] RST_MOTOR_V = 16'h0022;
	localparam logic [15:0] RST_MOTOR_P = 16'h0004;
	localparam logic [15:0] RST_MODE = 16'h0030;
	localparam logic [15:0] MODE_WRITE_MASK = 16'h07FF;
	localparam logic [6:0] RST_NODE_ADDR = 7'h00;
	localparam logic [15:0] RST_BIT_DIV = 16'h0E10;

	function automatic logic [15:0] scr_user_reset(input int unsigned idx);
		logic [15:0] v;
		v = 16'h0000;
		if (idx == int'(REG_MOTOR_R)) v = RST_MOTOR_R;
		else if (idx == int'(REG_MOTOR_V)) v = RST_MOTOR_V;
		else if (idx == int'(REG_MOTOR_P)) v = RST_MOTOR_P;
		return v;
	endfunction

	// ---------------------------------------------------------------
	// Mode register layout and encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SCR_OP_SPEED = 2'b00,
		SCR_OP_POSITION = 2'b01,
		SCR_OP_TORQUE = 2'b10,
		SCR_OP_RESERVED = 2'b11
	} scr_op_mode_t;

	typedef enum logic [1:0] {
		SCR_SRC_SERIAL = 2'b00,
		SCR_SRC_RESERVED = 2'b01,
		SCR_SRC_PULSE_DIR = 2'b10,
		SCR_SRC_PWM_DIR = 2'b11
	} scr_cmd_src_t;

	typedef struct packed {
		logic [4:0] reserved;
		logic undervoltage_lockout_enable;
		logic feedforward_enable;
		logic s_profile_enable;
		logic step_resolution_source;
		logic bridge_combined;
		logic standby_disable;
		logic absolute_position;
		scr_cmd_src_t cmd_source;
		scr_op_mode_t op_mode;
	} scr_mode_cfg_t;

	typedef struct packed {
		logic valid;
		logic ok;
		logic [7:0] data;
	} scr_rx_char_t;

	typedef enum logic [2:0] {
		PKT_SLAVE = 3'b000,
		PKT_REGADDR = 3'b001,
		PKT_DATA_HI = 3'b010,
		PKT_DATA_LO = 3'b011,
		PKT_REPLY = 3'b100
	} scr_pkt_state_t;

	function automatic logic [10:0] scr_frame(input logic [7:0] d);
		return {1'b1, ~^d, d, 1'b0};
	endfunction

endpackage

// ===== scr_port.sv
// Serial configuration register port: half-duplex link, packet decoder and register bank
`timescale 1ns/10ps
`default_nettype none
module scr_port #(
	parameter int unsigned CLK_HZ = scr_pkg::CLK_HZ,
	parameter logic [15:0] PART_NUMBER_ID = 16'h0A5A, // Arbitrary value
	parameter logic [15:0] PART_VERSION_ID = 16'h0001, // Arbitrary value
	parameter int unsigned STEP_W = 4,
	parameter int unsigned GAP_BITS = scr_pkg::GAP_BITS
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_rx,
	input wire logic i_enable_n,
	input wire logic i_start_cmd,
	input wire logic [STEP_W-1:0] i_step_switches,
	output logic o_tx,
	output logic o_transceiver_direction,
	output scr_pkg::scr_mode_cfg_t o_mode_cfg,
	output logic o_speed_mode,
	output logic o_position_mode,
	output logic o_torque_mode,
	output logic o_pulse_dir_input,
	output logic o_pwm_dir_input,
	output logic o_six_pwm_drive,
	output logic o_motor_run,
	output logic [STEP_W-1:0] o_step_resolution,
	output logic [15:0] o_motor_phase_resistance,
	output logic [15:0] o_motor_rated_voltage,
	output logic [15:0] o_motor_pole_pairs,
	output logic [6:0] o_node_address,
	output logic [15:0] o_bit_rate_divisor
);
	import scr_pkg::*;

	localparam logic [28:0] CLK_HZ_W = 29'(CLK_HZ);
	localparam logic [11:0] GAP_LIMIT = 12'(GAP_BITS * OVERSAMPLE);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic rx_meta_q, rx_sync_q, rx_prev_q;
	logic en_meta_q, en_sync_q;
	logic [STEP_W-1:0] sw_meta_q, sw_sync_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			rx_prev_q <= 1'b1;
			en_meta_q <= 1'b1;
			en_sync_q <= 1'b1;
			sw_meta_q <= '0;
			sw_sync_q <= '0;
		end else if (i_clk_en) begin
			rx_meta_q <= i_rx;
			rx_sync_q <= rx_meta_q;
			rx_prev_q <= rx_sync_q;
			en_meta_q <= i_enable_n;
			en_sync_q <= en_meta_q;
			sw_meta_q <= i_step_switches;
			sw_sync_q <= sw_meta_q;
		end
	end

	// ---------------------------------------------------------------
	// Oversample tick: rate = divisor * 32 * 16 per second
	// ---------------------------------------------------------------
	// A divisor of zero stops the ticks, and with them the whole link
	logic [27:0] acc_q;
	logic [15:0] div_q;
	wire [27:0] nco_inc = 28'(div_q) << DIV_SHIFT;
	wire [28:0] nco_sum = {1'b0, acc_q} + {1'b0, nco_inc};
	wire tick = (nco_sum >= CLK_HZ_W);
	wire [27:0] acc_d = tick ? 28'(nco_sum - CLK_HZ_W) : nco_sum[27:0];

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) acc_q <= '0;
		else if (i_clk_en) acc_q <= acc_d;
	end

	// ---------------------------------------------------------------
	// Receiver
	// ---------------------------------------------------------------
	logic rx_busy_q;
	logic [3:0] rx_tick_q, rx_bit_q;
	logic [9:0] rx_shift_q;
	scr_rx_char_t rx_char_q;
	wire rx_start = !rx_busy_q && rx_prev_q && !rx_sync_q;
	wire rx_sample = rx_busy_q && tick && (rx_tick_q == SAMPLE_TICK);
	wire rx_false_start = rx_sample && (rx_bit_q == 4'h0) && rx_sync_q;
	wire rx_last = rx_sample && (rx_bit_q == STOP_BIT_IDX);
	wire [9:0] rx_frame = {rx_sync_q, rx_shift_q[9:1]};
	wire rx_frame_ok = rx_frame[9] && (^rx_frame[8:0]);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_busy_q <= 1'b0;
			rx_tick_q <= '0;
			rx_bit_q <= '0;
			rx_shift_q <= '0;
			rx_char_q <= '0;
		end else if (i_clk_en) begin
			rx_char_q.valid <= rx_last;
			if (rx_last) begin
				rx_char_q.ok <= rx_frame_ok;
				rx_char_q.data <= rx_frame[7:0];
			end
			if (rx_start) begin
				rx_busy_q <= 1'b1;
				rx_tick_q <= '0;
				rx_bit_q <= '0;
			end else if (rx_busy_q && tick) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				if (rx_false_start || rx_last) rx_busy_q <= 1'b0;
				if (rx_sample) begin
					rx_bit_q <= rx_bit_q + 4'h1;
					rx_shift_q <= rx_frame;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Packet decoder
	// ---------------------------------------------------------------
	scr_pkt_state_t pkt_q;
	logic addressed_q;
	logic [6:0] reg_addr_q;
	logic [7:0] data_hi_q;
	logic [11:0] gap_q;
	logic tx_busy_q, tx_pending_q;
	logic [3:0] tx_tick_q, tx_bit_q;
	logic [10:0] tx_shift_q;
	logic [7:0] tx_lo_q;
	logic [6:0] node_q;

	wire char_good = rx_char_q.valid && rx_char_q.ok;
	wire char_bad = rx_char_q.valid && !rx_char_q.ok;
	wire gap_expired = (gap_q == GAP_LIMIT);
	wire tx_char_end = tx_busy_q && tick && (tx_tick_q == LAST_TICK) && (tx_bit_q == STOP_BIT_IDX);
	wire tx_done = tx_char_end && !tx_pending_q;
	wire read_req = (pkt_q == PKT_REGADDR) && char_good && !rx_char_q.data[7] && addressed_q;
	wire wr_en = (pkt_q == PKT_DATA_LO) && char_good && addressed_q;
	wire [15:0] wr_data = {data_hi_q, rx_char_q.data};

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pkt_q <= PKT_SLAVE;
			addressed_q <= 1'b0;
			reg_addr_q <= '0;
			data_hi_q <= '0;
			gap_q <= '0;
		end else if (i_clk_en) begin
			if (rx_char_q.valid || pkt_q == PKT_SLAVE || pkt_q == PKT_REPLY) gap_q <= '0;
			else if (tick && !gap_expired) gap_q <= gap_q + 12'h001;
			case (pkt_q)
				PKT_SLAVE: begin
					if (char_good) begin
						addressed_q <= (rx_char_q.data[6:0] == node_q);
						pkt_q <= PKT_REGADDR;
					end
				end
				PKT_REGADDR: begin
					if (char_good) begin
						reg_addr_q <= rx_char_q.data[6:0];
						if (rx_char_q.data[7]) pkt_q <= PKT_DATA_HI;
						else if (addressed_q) pkt_q <= PKT_REPLY;
						else pkt_q <= PKT_SLAVE;
					end
				end
				PKT_DATA_HI: begin
					if (char_good) begin
						data_hi_q <= rx_char_q.data;
						pkt_q <= PKT_DATA_LO;
					end
				end
				PKT_DATA_LO: begin
					if (char_good) pkt_q <= PKT_SLAVE;
				end
				PKT_REPLY: begin
					if (tx_done) pkt_q <= PKT_SLAVE;
				end
				default: pkt_q <= PKT_SLAVE;
			endcase
			// Own echo heard while replying is ignored; only the reply end leaves
			if ((char_bad || gap_expired) && pkt_q != PKT_REPLY) pkt_q <= PKT_SLAVE;
		end
	end

	// ---------------------------------------------------------------
	// Register bank
	// ---------------------------------------------------------------
	logic [15:0] user_q [USER_WORDS];
	scr_mode_cfg_t mode_q;

	generate
		for (genvar gi = 0; gi < USER_WORDS; gi++) begin : g_user
			if (gi == int'(REG_PART_NUMBER) || gi == int'(REG_PART_VERSION)) begin : g_ro
				assign user_q[gi] = (gi == int'(REG_PART_NUMBER)) ? PART_NUMBER_ID : PART_VERSION_ID;
			end else begin : g_rw
				always_ff @(posedge i_clk or negedge i_reset_n) begin
					if (!i_reset_n) user_q[gi] <= scr_user_reset(gi);
					else if (i_clk_en && wr_en && reg_addr_q == 7'(gi)) user_q[gi] <= wr_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_q <= RST_MODE;
			node_q <= RST_NODE_ADDR;
			div_q <= RST_BIT_DIV;
		end else if (i_clk_en && wr_en) begin
			if (reg_addr_q == REG_MODE) mode_q <= wr_data & MODE_WRITE_MASK;
			else if (reg_addr_q == REG_NODE_ADDR) node_q <= wr_data[6:0];
			else if (reg_addr_q == REG_BIT_DIV) div_q <= wr_data;
		end
	end


	// ---------------------------------------------------------------
	// Read data select
	// ---------------------------------------------------------------
	// The reply loads as the address byte is taken, before reg_addr_q holds it
	wire [6:0] rd_addr = rx_char_q.data[6:0];
	wire in_user = (rd_addr < 7'(USER_WORDS));
	wire [15:0] rd_data = in_user ? user_q[5'(rd_addr)] :
		(rd_addr == REG_MODE) ? 16'(mode_q) :
		(rd_addr == REG_NODE_ADDR) ? {9'h000, node_q} :
		(rd_addr == REG_BIT_DIV) ? div_q : 16'h0000;

	// ---------------------------------------------------------------
	// Transmitter: high byte then low byte
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_busy_q <= 1'b0;
			tx_pending_q <= 1'b0;
			tx_tick_q <= '0;
			tx_bit_q <= '0;
			tx_shift_q <= '1;
			tx_lo_q <= '0;
		end else if (i_clk_en) begin
			// Reply starts at mid stop bit of the address byte, with no turnaround gap
			if (read_req) begin
				tx_busy_q <= 1'b1;
				tx_pending_q <= 1'b1;
				tx_tick_q <= '0;
				tx_bit_q <= '0;
				tx_shift_q <= scr_frame(rd_data[15:8]);
				tx_lo_q <= rd_data[7:0];
			end else if (tx_busy_q && tick) begin
				tx_tick_q <= tx_tick_q + 4'h1;
				if (tx_tick_q == LAST_TICK) begin
					if (tx_bit_q == STOP_BIT_IDX) begin
						tx_bit_q <= '0;
						tx_pending_q <= 1'b0;
						tx_busy_q <= tx_pending_q;
						tx_shift_q <= tx_pending_q ? scr_frame(tx_lo_q) : '1;
					end else begin
						tx_bit_q <= tx_bit_q + 4'h1;
						tx_shift_q <= {1'b1, tx_shift_q[10:1]};
					end
				end
			end
		end
	end

	assign o_tx = tx_shift_q[0];
	assign o_transceiver_direction = tx_busy_q;

	// ---------------------------------------------------------------
	// Mode decode and standby control
	// ---------------------------------------------------------------
	logic speed_q, position_q, torque_q, pulse_q, pwm_q, six_pwm_q, run_q;
	logic [STEP_W-1:0] step_q;
	wire standby_active = !mode_q.standby_disable && (mode_q.cmd_source == SCR_SRC_PULSE_DIR);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			speed_q <= 1'b0;
			position_q <= 1'b0;
			torque_q <= 1'b0;
			pulse_q <= 1'b0;
			pwm_q <= 1'b0;
			six_pwm_q <= 1'b0;
			run_q <= 1'b0;
			step_q <= '0;
		end else if (i_clk_en) begin
			speed_q <= (mode_q.op_mode == SCR_OP_SPEED);
			position_q <= (mode_q.op_mode == SCR_OP_POSITION);
			torque_q <= (mode_q.op_mode == SCR_OP_TORQUE);
			pulse_q <= (mode_q.cmd_source == SCR_SRC_PULSE_DIR);
			pwm_q <= (mode_q.cmd_source == SCR_SRC_PWM_DIR);
			six_pwm_q <= !mode_q.bridge_combined;
			step_q <= mode_q.step_resolution_source ? sw_sync_q : user_q[5'(REG_STEP_RES)][STEP_W-1:0];
			if (en_sync_q) run_q <= 1'b0;
			else if (!standby_active) run_q <= 1'b1;
			else if (i_start_cmd) run_q <= 1'b1;
		end
	end

	assign o_mode_cfg = mode_q;
	assign o_speed_mode = speed_q;
	assign o_position_mode = position_q;
	assign o_torque_mode = torque_q;
	assign o_pulse_dir_input = pulse_q;
	assign o_pwm_dir_input = pwm_q;
	assign o_six_pwm_drive = six_pwm_q;
	assign o_motor_run = run_q;
	assign o_step_resolution = step_q;
	assign o_motor_phase_resistance = user_q[5'(REG_MOTOR_R)];
	assign o_motor_rated_voltage = user_q[5'(REG_MOTOR_V)];
	assign o_motor_pole_pairs = user_q[5'(REG_MOTOR_P)];
	assign o_node_address = node_q;
	assign o_bit_rate_divisor = div_q;

endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench of the serial configuration register port
`timescale 1ns/10ps
`default_nettype none
module tb;
	import scr_pkg::*;
	localparam int BIT = 32;
	localparam logic [15:0] PART_NO = 16'h0A5A; // Arbitrary value
	localparam logic [15:0] PART_REV = 16'h0001; // Arbitrary value
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic enable_n = 1'b1;
	logic start_cmd = 1'b0;
	logic [3:0] switches = 4'h0;
	logic host_txd, host_drive, tx, dir, spd, pos, trq, pul, pwm, six, run;
	logic [3:0] step;
	logic [6:0] node;
	logic [15:0] res, volt, poles, div;
	scr_mode_cfg_t cfg;
	wire logic line = dir ? tx : (host_drive ? host_txd : 1'b1);
	int bad_count = 0;
	int n_checks = 0;

	scr_port #(.CLK_HZ(3_686_400), .PART_NUMBER_ID(PART_NO), .PART_VERSION_ID(PART_REV)) DUT (
		.i_clk(clk), .i_reset_n(reset_n), .i_clk_en(1'b1), .i_rx(line), .i_enable_n(enable_n),
		.i_start_cmd(start_cmd), .i_step_switches(switches), .o_tx(tx), .o_transceiver_direction(dir),
		.o_mode_cfg(cfg), .o_speed_mode(spd), .o_position_mode(pos), .o_torque_mode(trq),
		.o_pulse_dir_input(pul), .o_pwm_dir_input(pwm), .o_six_pwm_drive(six), .o_motor_run(run),
		.o_step_resolution(step), .o_motor_phase_resistance(res), .o_motor_rated_voltage(volt),
		.o_motor_pole_pairs(poles), .o_node_address(node), .o_bit_rate_divisor(div)
	);
	scr_host #(.BIT_CYC(BIT)) u_host (
		.i_clk(clk), .i_line(line), .i_dev_drive(dir), .o_txd(host_txd), .o_drive(host_drive)
	);

	initial begin
		forever #2 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Shared helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [6:0] nd, input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] v;
		logic ok;
		u_host.read_reg(nd, a, v, ok);
		check({15'h0000, ok}, 16'h0001);
		check(v, exp);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values();
		logic [6:0] a [9] = '{7'h00, 7'h01, 7'h06, 7'h08, 7'h14, 7'h34, 7'h5C, 7'h5D, 7'h40};
		logic [15:0] e [9] = '{PART_NO, 16'h010E, 16'h0022, 16'h0004, PART_REV, 16'h0030, 16'h0000,
			16'h0E10, 16'h0000};
		check(cfg, 16'h0030);
		check(div, 16'h0E10);
		check({res[7:0], volt[7:0]}, 16'h0E22);
		check({poles[7:0], 1'b0, node}, 16'h0400);
		for (int i = 0; i < 9; i++) rd(7'h00, a[i], e[i]);
	endtask

	task automatic t_user_words();
		logic [6:0] a [4] = '{7'h02, 7'h13, 7'h01, 7'h00};
		logic [15:0] v [4] = '{16'hA5C3, 16'h3C5A, 16'h1111, 16'hFFFF};
		for (int i = 0; i < 4; i++) u_host.write_reg(7'h00, a[i], v[i]);
		u_host.write_reg(7'h00, 7'h06, 16'h0018);
		u_host.write_reg(7'h00, 7'h08, 16'h0007);
		for (int i = 0; i < 4; i++) rd(7'h00, a[i], (i == 3) ? PART_NO : v[i]);
		check(res, 16'h1111);
		check(volt, 16'h0018);
		check(poles, 16'h0007);
		check({12'h000, step}, 16'h0003);
	endtask

	task automatic t_mode();
		logic [15:0] v [4] = '{16'h0000, 16'h0755, 16'h02AA, 16'h07FF};
		logic [15:0] m;
		switches = 4'h9;
		for (int i = 0; i < 4; i++) begin
			m = v[i] & 16'h07FF;
			u_host.write_reg(7'h00, 7'h34, v[i]);
			check(cfg, m);
			check({10'h000, spd, pos, trq, pul, pwm, six}, {10'h000, m[1:0] == 2'b00, m[1:0] == 2'b01,
				m[1:0] == 2'b10, m[3:2] == 2'b10, m[3:2] == 2'b11, !m[6]});
			check({12'h000, step}, m[7] ? 16'h0009 : 16'h0003);
		end
	endtask

	task automatic t_run();
		u_host.write_reg(7'h00, 7'h34, 16'h0008);
		enable_n = 1'b0;
		repeat (8) @(negedge clk);
		check({15'h0000, run}, 16'h0000);
		start_cmd = 1'b1;
		@(negedge clk);
		start_cmd = 1'b0;
		repeat (2) @(negedge clk);
		check({15'h0000, run}, 16'h0001);
		enable_n = 1'b1;
		repeat (5) @(negedge clk);
		check({15'h0000, run}, 16'h0000);
		u_host.write_reg(7'h00, 7'h34, 16'h0028);
		enable_n = 1'b0;
		repeat (5) @(negedge clk);
		check({15'h0000, run}, 16'h0001);
		enable_n = 1'b1;
	endtask

	task automatic t_node();
		logic [15:0] v;
		logic ok;
		u_host.write_reg(7'h00, 7'h5C, 16'h002A);
		check({9'h000, node}, 16'h002A);
		u_host.write_reg(7'h00, 7'h01, 16'hDEAD);
		u_host.read_reg(7'h00, 7'h01, v, ok);
		check({ok, res[14:0]}, 16'h1111);
		u_host.write_reg(7'h2A, 7'h01, 16'h1234);
		check(res, 16'h1234);
		u_host.send_char(8'h2A, 1'b0);
		u_host.send_char(8'h81, 1'b1);
		u_host.send_char(8'hBE, 1'b0);
		u_host.send_char(8'hEF, 1'b0);
		repeat (24 * BIT) @(negedge clk);
		check(res, 16'h1234);
		rd(7'h2A, 7'h01, 16'h1234);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset_values();
		t_user_words();
		t_mode();
		t_run();
		t_node();
		end_of_test();
	end

	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
